// file: hw/tmr_cc_pkg.sv
// Package: register map, field layout and state types of the capture/compare block
package tmr_cc_pkg;

  // --------------------------------
  // Register byte offsets
  // --------------------------------
  localparam logic [7:0] OFF_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFF_CHAN_CFG   = 8'h20;
  localparam logic [7:0] OFF_CHAN_STAT  = 8'h24;
  localparam logic [7:0] OFF_CH2_VALUE  = 8'h38;
  localparam logic [7:0] OFF_CH4_VALUE  = 8'h40;
  localparam logic [7:0] OFF_BURST_CTRL = 8'h48;
  localparam logic [7:0] OFF_BURST_WIN  = 8'h4C;

  // --------------------------------
  // Field positions
  // --------------------------------
  localparam int EXT_EN_BIT      = 10;
  localparam int CFG_STRIDE      = 4;
  localparam int BURST_LEN_LSB   = 8;
  localparam int BURST_START_LSB = 0;
  localparam int BURST_FIELD_W   = 5;

  // --------------------------------
  // Constant values
  // --------------------------------
  localparam logic [31:0] MASK_NARROW = 32'h0000FFFF;
  localparam logic [31:0] MASK_WIDE   = 32'hFFFFFFFF;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [4:0]  BURST_FIRST = 5'h00;

  // --------------------------------
  // State types
  // --------------------------------
  typedef struct packed {
    logic buf_en;
    logic out_mode;
    logic pol;
    logic en;
  } chan_cfg_t;

  typedef struct packed {
    logic [31:0] value;
    logic [31:0] active;
    logic        out;
  } chan_st_t;

  typedef struct packed {
    logic [4:0] pos;
  } burst_st_t;

  typedef struct packed {
    logic        aw_full;
    logic [7:0]  awaddr;
    logic        w_full;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        ext_en;
    logic [11:0] cfg;
    logic [4:0]  burst_len;
    logic [4:0]  burst_start;
  } bus_st_t;

  // --------------------------------
  // Reset values
  // --------------------------------
  localparam chan_st_t  RST_CHAN  = '{default: '0};
  localparam burst_st_t RST_BURST = '{default: '0};
  localparam bus_st_t   RST_BUS   = '{default: '0};

endpackage

// file: hw/chan_cc.sv
// Module: one channel's capture/compare value, compare buffer and output stage
`timescale 1ns/1ps
`default_nettype none
module chan_cc
  import tmr_cc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Configuration
  input  wire chan_cfg_t   cfg,
  input  wire logic        wide,
  // Timer events
  input  wire logic [31:0] counter_value,
  input  wire logic        input_event,
  input  wire logic        overflow_event,
  // Register write
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  // Results
  output logic      [31:0] value,
  output logic             compare_out
);

  chan_st_t    q;
  chan_st_t    d;
  logic [31:0] mask;
  logic [31:0] cnt;
  logic        raw;

  assign mask = wide ? MASK_WIDE : MASK_NARROW;
  assign cnt  = counter_value & mask;
  assign raw  = cnt < q.active;

  always_comb begin
    d = q;
    if (cfg.out_mode) begin
      if (wr_en) begin
        d.value = wr_data;
        if (!cfg.buf_en) d.active = wr_data;
      end
      // Old buffered value moves even if a write lands now
      if (overflow_event && cfg.buf_en) d.active = q.value;
    end else if (input_event) begin
      d.value = cnt;
    end else if (wr_en) begin
      d.value = wr_data;
    end
    d.value  = d.value & mask;
    d.active = d.active & mask;
    d.out    = cfg.en && cfg.out_mode && (raw ^ cfg.pol);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST_CHAN;
    end else if (ce) begin
      q <= d;
    end
  end

  assign value       = q.value;
  assign compare_out = q.out;

  // --------------------------------
  // Checks
  // --------------------------------
  chk_capture_count:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !cfg.out_mode && input_event |=> value == $past(cnt))
    else $error("capture value not loaded");

  chk_direct_load:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cfg.out_mode && wr_en && !cfg.buf_en && !overflow_event
    |=> q.active == $past(wr_data & mask))
    else $error("unbuffered compare not loaded at once");

  chk_buffer_hold:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cfg.out_mode && cfg.buf_en && !overflow_event && wide == $past(wide)
    |=> q.active == $past(q.active))
    else $error("buffered compare changed without overflow");

  chk_overflow_move:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cfg.out_mode && cfg.buf_en && overflow_event
    |=> q.active == ($past(q.value) & $past(mask)))
    else $error("buffer not moved at overflow");

  chk_disabled_low:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !cfg.en |=> !compare_out)
    else $error("disabled channel output high");

  chk_narrow_upper:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !wide |=> value[31:16] == 16'h0000)
    else $error("upper half set while narrow");

  cov_capture: cover property (@(posedge aclk) disable iff (!aresetn)
    ce && !cfg.out_mode && input_event);

  cov_buffer_move: cover property (@(posedge aclk) disable iff (!aresetn)
    ce && cfg.out_mode && cfg.buf_en && overflow_event);

endmodule // chan_cc
`default_nettype wire

// file: hw/burst_index.sv
// Module: position counter of the burst window and target word index
`timescale 1ns/1ps
`default_nettype none
module burst_index
  import tmr_cc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Window setup
  input  wire logic [4:0] start,
  input  wire logic [4:0] length,
  input  wire logic       restart,
  input  wire logic       step,
  // Target
  output logic      [5:0] target,
  output logic      [4:0] pos
);

  burst_st_t q;
  burst_st_t d;

  always_comb begin
    d = q;
    if (restart) begin
      d.pos = BURST_FIRST;
    end else if (step) begin
      // Length code n means n+1 accesses
      d.pos = (q.pos == length) ? BURST_FIRST : q.pos + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST_BURST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign pos    = q.pos;
  assign target = {1'b0, start} + {1'b0, q.pos};

  // --------------------------------
  // Checks
  // --------------------------------
  chk_burst_wrap:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ce && step && !restart && q.pos == length |=> q.pos == BURST_FIRST)
    else $error("burst did not wrap after last access");

  chk_burst_step:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ce && step && !restart && q.pos != length |=> q.pos == $past(q.pos) + 5'h01)
    else $error("burst did not advance");

  chk_burst_range:
  assert property (@(posedge aclk) disable iff (!aresetn)
    q.pos <= length)
    else $error("burst position beyond length");

  cov_long_burst: cover property (@(posedge aclk) disable iff (!aresetn)
    ce && step && length == 5'h11 && q.pos == 5'h11);

endmodule // burst_index
`default_nettype wire

// file: hw/timer_channel_data_dma_burst.sv
// Module: channel 2-4 capture/compare registers and burst window, AXI4-Lite slave
//
// Contract
// - input mode stores counter value at each channel input event
// - output mode compares stored value against running counter to drive output
// - buffer enable clear loads written compare at once, else holds it buffered
// - data registers are 16 bits, 32 only with extended width enabled
// - burst length field bits 12:8, count is field plus one, resets zero
// - start offset field bits 4:0 is first word index from control one
// - each window access reaches next register from start to start plus length
// - channel output low when disabled or in input mode, else raw compare with polarity applied
// - counter width widens to 32 bits with extended width enabled
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_data_dma_burst
  import tmr_cc_pkg::*;
#(
  parameter bit EXT_CAPABLE = 1'b1
)(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // Write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // Read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Timer side
  input  wire logic [31:0] counter_value,
  input  wire logic [2:0]  channel_input_event,
  input  wire logic        overflow_event,
  // Compare outputs
  output logic             channel2_compare_output,
  output logic             channel3_compare_output,
  output logic             channel4_compare_output
);

  // --------------------------------
  // Declarations
  // --------------------------------
  bus_st_t          q;
  bus_st_t          d;
  logic [2:0][31:0] ch_value;
  logic [2:0]       ch_out;
  logic [2:0]       ch_wr;
  logic [31:0]      wr_merged;
  logic [32:0]      wr_old;
  logic [32:0]      rd_look;
  logic [5:0]       widx;
  logic [5:0]       ridx;
  logic [5:0]       target;
  logic [4:0]       burst_pos;
  logic [3:0]       strb;
  logic             wide;
  logic             wr_fire;
  logic             rd_fire;
  logic             wr_win;
  logic             rd_win;
  logic             step;
  logic             restart;

  // --------------------------------
  // Register lookup
  // --------------------------------
  // Bit 32 flags a mapped word; the window itself is never a target
  function automatic logic [32:0] lookup(
    input logic [5:0]       idx,
    input bus_st_t          s,
    input logic [2:0][31:0] cv,
    input logic [2:0]       co
  );
    logic [32:0] r;
    r = '0;
    case (idx)
      OFF_CTRL_ONE[7:2]: begin
        r[32]         = 1'b1;
        r[EXT_EN_BIT] = s.ext_en;
      end
      OFF_CHAN_CFG[7:2]: begin
        r[32]             = 1'b1;
        r[$bits(s.cfg)-1:0] = s.cfg;
      end
      OFF_CHAN_STAT[7:2]: begin
        r[32]  = 1'b1;
        r[2:0] = co;
      end
      OFF_BURST_CTRL[7:2]: begin
        r[32] = 1'b1;
        r[BURST_LEN_LSB +: BURST_FIELD_W]   = s.burst_len;
        r[BURST_START_LSB +: BURST_FIELD_W] = s.burst_start;
      end
      default: begin
        if (idx >= OFF_CH2_VALUE[7:2] && idx <= OFF_CH4_VALUE[7:2]) begin
          r = {1'b1, cv[2'(idx - OFF_CH2_VALUE[7:2])]};
        end
      end
    endcase
    return r;
  endfunction

  // --------------------------------
  // Handshakes and address steering
  // --------------------------------
  // Readies drop with ce so that no beat is taken while state is frozen
  assign awready = ce & ~q.aw_full & ~q.bvalid;
  assign wready  = ce & ~q.w_full & ~q.bvalid;
  assign wr_fire = ce & q.aw_full & q.w_full & ~q.bvalid;
  // Write has priority so one cycle never steps the window twice
  assign arready = ce & ~q.rvalid & ~wr_fire;
  assign rd_fire = arvalid & arready;

  assign wr_win  = q.awaddr[7:2] == OFF_BURST_WIN[7:2];
  assign rd_win  = araddr[7:2] == OFF_BURST_WIN[7:2];
  assign widx    = wr_win ? target : q.awaddr[7:2];
  assign ridx    = rd_win ? target : araddr[7:2];
  assign step    = (wr_fire & wr_win) | (rd_fire & rd_win);
  assign restart = wr_fire & (widx == OFF_BURST_CTRL[7:2]);

  // Window carries 16 bits only
  assign strb    = wr_win ? (q.wstrb & 4'h3) : q.wstrb;
  assign wr_old  = lookup(widx, q, ch_value, ch_out);
  assign rd_look = lookup(ridx, q, ch_value, ch_out);
  assign wide    = EXT_CAPABLE & q.ext_en;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_merged[8*b +: 8] = strb[b] ? q.wdata[8*b +: 8] : wr_old[8*b +: 8];
    end
  end

  // --------------------------------
  // Bus state
  // --------------------------------
  always_comb begin
    d = q;
    if (awvalid && awready) begin
      d.aw_full = 1'b1;
      d.awaddr  = awaddr;
    end
    if (wvalid && wready) begin
      d.w_full = 1'b1;
      d.wdata  = wdata;
      d.wstrb  = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wr_old[32] ? RESP_OKAY : RESP_SLVERR;
      case (widx)
        OFF_CTRL_ONE[7:2]: begin
          d.ext_en = wr_merged[EXT_EN_BIT];
        end
        OFF_CHAN_CFG[7:2]: begin
          d.cfg = wr_merged[$bits(d.cfg)-1:0];
        end
        OFF_BURST_CTRL[7:2]: begin
          d.burst_len   = wr_merged[BURST_LEN_LSB +: BURST_FIELD_W];
          d.burst_start = wr_merged[BURST_START_LSB +: BURST_FIELD_W];
        end
        default: begin
        end
      endcase
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      d.rvalid = 1'b1;
      d.rresp  = rd_look[32] ? RESP_OKAY : RESP_SLVERR;
      d.rdata  = rd_win ? {16'h0000, rd_look[15:0]} : rd_look[31:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST_BUS;
    end else if (ce) begin
      q <= d;
    end
  end

  assign bvalid = q.bvalid;
  assign bresp  = q.bresp;
  assign rvalid = q.rvalid;
  assign rresp  = q.rresp;
  assign rdata  = q.rdata;

  // --------------------------------
  // Burst window
  // --------------------------------
  burst_index u_burst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (q.burst_start),
    .length  (q.burst_len),
    .restart (restart),
    .step    (step),
    .target  (target),
    .pos     (burst_pos)
  );

  // --------------------------------
  // Channels 2 to 4
  // --------------------------------
  for (genvar c = 0; c < 3; c++) begin : g_chan
    localparam logic [5:0] CH_IDX = OFF_CH2_VALUE[7:2] + 6'(c);

    assign ch_wr[c] = wr_fire & (widx == CH_IDX);

    chan_cc u_chan (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .ce             (ce),
      .cfg            (chan_cfg_t'(q.cfg[c*CFG_STRIDE +: CFG_STRIDE])),
      .wide           (wide),
      .counter_value  (counter_value),
      .input_event    (channel_input_event[c]),
      .overflow_event (overflow_event),
      .wr_en          (ch_wr[c]),
      .wr_data        (wr_merged),
      .value          (ch_value[c]),
      .compare_out    (ch_out[c])
    );
  end

  assign channel2_compare_output = ch_out[0];
  assign channel3_compare_output = ch_out[1];
  assign channel4_compare_output = ch_out[2];

  // --------------------------------
  // Checks
  // --------------------------------
  chk_window_read:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_win && ridx == OFF_CH2_VALUE[7:2]
    |=> rvalid && rdata == {16'h0000, $past(ch_value[0][15:0])})
    else $error("window read did not return channel 2 value");

  chk_window_offset:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_win && burst_pos == BURST_FIRST
    |-> ridx == {1'b0, q.burst_start})
    else $error("burst did not start at start offset");

  chk_write_answer:
  assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> bvalid ##1 (bvalid || $past(bready)))
    else $error("write response dropped early");

  chk_read_hold:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed before it was taken");

  chk_ready_frozen:
  assert property (@(posedge aclk) disable iff (!aresetn)
    !ce |-> !awready && !wready && !arready)
    else $error("beat offered while state is frozen");

  chk_restart_first:
  assert property (@(posedge aclk) disable iff (!aresetn)
    restart |=> burst_pos == BURST_FIRST)
    else $error("burst position not cleared by control write");

  chk_window_narrow:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_win |=> rdata[31:16] == 16'h0000)
    else $error("window read returned upper half");

  chk_unmapped_error:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && !rd_look[32] |=> rresp == RESP_SLVERR && rdata == 32'h00000000)
    else $error("unmapped read not refused");

  chk_status_bits:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && ridx == OFF_CHAN_STAT[7:2] |=> rdata == {29'h0000000, $past(ch_out)})
    else $error("status read differs from compare outputs");

  cov_window_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_win && wr_old[32]);

  cov_window_wrap: cover property (@(posedge aclk) disable iff (!aresetn)
    step && burst_pos == q.burst_len && q.burst_len != 5'h00);

endmodule // timer_channel_data_dma_burst
`default_nettype wire

// file: verif/axil_host.sv
// AXI4-Lite master standing in for software and the DMA controller
`timescale 1ns/1ps
`default_nettype none
module axil_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic      [7:0]  awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic      [31:0] wdata,
  output logic      [3:0]  wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels
  output logic      [7:0]  araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Ready and answers are sampled at the very edge that takes them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr  <= ~a;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // axil_host
`default_nettype wire

// file: verif/tb_timer_channel_data_dma_burst.sv
// Self-checking bench of the channel value registers and the burst window
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_data_dma_burst
  import tmr_cc_pkg::*;
;
  logic        aclk, aresetn, ce, overflow_event;
  logic [2:0]  channel_input_event, co;
  logic [31:0] counter_value, wdata, rdata, seed, msk, a, b0, b1, c;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int          mismatches, n_compared, cycles, bstart, blen, bpos, t;
  int          exp_v[3];

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  timer_channel_data_dma_burst dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .counter_value(counter_value), .channel_input_event(channel_input_event), .overflow_event(overflow_event),
    .channel2_compare_output(co[0]), .channel3_compare_output(co[1]), .channel4_compare_output(co[2]));

  axil_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  // ----------------------------------------
  // Helpers and reference model
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  // Window target word, then advance with wrap after the last transfer
  function automatic int tgt();
    int r;
    r = bstart + bpos;
    bpos = (bpos == blen) ? 0 : bpos + 1;
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    host.rd(ad, d, resp);
    chk(d, e);
    chk({30'h0, resp}, {30'h0, er});
  endtask

  task automatic wr_chk(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    host.wr(ad, d, 4'hF, resp);
    chk({30'h0, resp}, {30'h0, er});
  endtask

  task automatic pulse_in(input int ch, input logic [31:0] cnt);
    @(posedge aclk);
    counter_value <= cnt;
    channel_input_event <= 3'(1 << ch);
    @(posedge aclk);
    channel_input_event <= 3'h0;
  endtask

  // Outputs are registered, so three edges are more than enough to settle
  task automatic outs(input logic [31:0] cnt, input logic [2:0] e);
    @(posedge aclk);
    counter_value <= cnt;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk({29'h0, co}, {29'h0, e});
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {aresetn, overflow_event, channel_input_event, counter_value} = '0;
    ce = 1'b1;
    seed = 32'hA532A8C9;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) rd_chk(OFF_CH2_VALUE + 8'(4 * i), 32'h0, RESP_OKAY);
    rd_chk(OFF_BURST_CTRL, 32'h0, RESP_OKAY);
    rd_chk(8'h7C, 32'h0, RESP_SLVERR);
    $display("test reset done");

    wr_chk(OFF_CHAN_CFG, 32'h111, RESP_OKAY);
    for (int w = 1; w >= 0; w--) begin
      wr_chk(OFF_CTRL_ONE, 32'(w) << EXT_EN_BIT, RESP_OKAY);
      msk = (w == 1) ? MASK_WIDE : MASK_NARROW;
      for (int ch = 0; ch < 3; ch++) begin
        seed = lfsr(seed);
        pulse_in(ch, seed);
        exp_v[ch] = seed & msk;
        rd_chk(OFF_CH2_VALUE + 8'(4 * ch), exp_v[ch], RESP_OKAY);
      end
    end
    @(posedge aclk);
    ce <= 1'b0;
    pulse_in(0, ~seed);
    @(posedge aclk);
    ce <= 1'b1;
    rd_chk(OFF_CH2_VALUE, exp_v[0], RESP_OKAY);
    $display("test capture done");

    seed = lfsr(seed);
    a = (seed & 32'h7FFF) | 32'h100;
    b0 = a >> 1;
    b1 = a + 32'h1;
    wr_chk(OFF_CHAN_CFG, 32'h575, RESP_OKAY);
    wr_chk(OFF_CH2_VALUE, a, RESP_OKAY);
    wr_chk(OFF_CH2_VALUE + 8'h4, a, RESP_OKAY);
    wr_chk(OFF_CH4_VALUE, b0, RESP_OKAY);
    rd_chk(OFF_CH2_VALUE + 8'h4, a, RESP_OKAY);
    wr_chk(OFF_CHAN_CFG, 32'hD75, RESP_OKAY);
    wr_chk(OFF_CH4_VALUE, b1, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      c = a - 32'h1 + 32'(k);
      outs(c, {c < b0, !(c < a), c < a});
    end
    @(posedge aclk);
    overflow_event <= 1'b1;
    @(posedge aclk);
    overflow_event <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      c = a - 32'h1 + 32'(k);
      outs(c, {c < b1, !(c < a), c < a});
    end
    wr_chk(OFF_CHAN_CFG, 32'hD74, RESP_OKAY);
    outs(a - 32'h1, {1'b1, 1'b0, 1'b0});
    rd_chk(OFF_CHAN_STAT, 32'h00000004, RESP_OKAY);
    $display("test compare done");

    wr_chk(OFF_CHAN_CFG, 32'h555, RESP_OKAY);
    bstart = OFF_CH2_VALUE >> 2;
    blen = 2;
    bpos = 0;
    wr_chk(OFF_BURST_CTRL, 32'(blen << BURST_LEN_LSB | bstart), RESP_OKAY);
    rd_chk(OFF_BURST_CTRL, 32'(blen << BURST_LEN_LSB | bstart), RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      t = tgt() - bstart;
      exp_v[t] = seed & MASK_NARROW;
      wr_chk(OFF_BURST_WIN, seed, RESP_OKAY);
    end
    for (int i = 0; i < 3; i++) rd_chk(OFF_CH2_VALUE + 8'(4 * i), exp_v[i], RESP_OKAY);
    wr_chk(OFF_BURST_CTRL, 32'(blen << BURST_LEN_LSB | bstart), RESP_OKAY);
    bpos = 0;
    for (int i = 0; i < 4; i++) rd_chk(OFF_BURST_WIN, exp_v[tgt() - bstart], RESP_OKAY);
    blen = 0;
    for (int s = 0; s < 3; s++) begin
      wr_chk(OFF_BURST_CTRL, 32'(s), RESP_OKAY);
      for (int i = 0; i < 2; i++) rd_chk(OFF_BURST_WIN, 32'h0, (s == 0) ? RESP_OKAY : RESP_SLVERR);
    end
    $display("test burst done");
    results();
  end
endmodule // tb_timer_channel_data_dma_burst
`default_nettype wire
